/* asfp_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module asfp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic clk,
    input  wire logic rst_b,
    asfp_stream_if.snk in_s,
    asfp_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_s.valid && in_s.ready;
    wire              pop  = out_s.valid && out_s.ready;

    assign in_s.ready  = (count != (AW+1)'(DEPTH));
    assign out_s.valid = (count != '0);
    assign out_s.data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : asfp_fifo

/* asfp_master.sv */
// Master that drives an asynchronous slave FIFO port through its pins
// Functional notes
// R01: Reads count only while chip select and read strobe are both low.
// R02: Chip select goes low before the read strobe goes low.
// R03: Output enable alone shows stale data from the previous read.
// R04: Fresh FIFO data follows the read strobe falling edge after a delay; the master takes the pin value 24 ns after the fall, short of the 30 ns delay.
// R05: Slave drives data only with output enable low; hold it during reads.
// R06: Output enable and read strobe may be one common signal.
// R07: Each read strobe shows the entry first, then the pointer advances.
// R08: Select lines and chip select are stable before the write strobe.
// R09: Chip select is low no later than the write strobe falls.
// R10: Write data is valid a setup margin before the write strobe rises.
// R11: Slave stores bus value on write strobe rising edge, then advances.
// R12: Slave flags update a bounded delay after each write strobe rise.
// R13: In bursts each write stores at current location then moves on.
// R14: Packet-end strobe commits written entries as a short packet.
// R15: Write strobe and packet-end are never low together.
// R16: Packet-end only after write strobe high for its least width.
// R17: Select lines stay unchanged while packet-end is low.
// R18: All strobes active low; each edge follows a held opposite level.
`timescale 1ns/1ps
`include "asfp_params.svh"
module asfp_master (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // Command side
    input  wire logic                   cmd_valid,
    input  wire logic [1:0]             cmd_op,
    input  wire logic [`ASFP_SEL_W-1:0] cmd_sel,
    input  wire logic [`ASFP_DATA_W-1:0] cmd_wdata,
    output logic                        cmd_ready,
    // Read data stream out of the FIFO
    output logic [`ASFP_DATA_W-1:0]     rd_data,
    output logic                        rd_valid,
    input  wire logic                   rd_ready,
    // Pins toward the slave
    output logic                        fifo_chip_select_n,
    output logic                        fifo_output_enable_n,
    output logic                        fifo_read_strobe_n,
    output logic                        fifo_write_strobe_n,
    output logic                        packet_commit_strobe_n,
    output logic [`ASFP_SEL_W-1:0]      fifo_select_bus,
    input  wire logic [`ASFP_DATA_W-1:0] fifo_data_in,
    output logic [`ASFP_DATA_W-1:0]     fifo_data_out,
    output logic                        fifo_data_oe
);
    localparam logic [`ASFP_CNT_W-1:0] CYC_LOW   = `ASFP_CNT_W'(`ASFP_CYC_LOW);
    localparam logic [`ASFP_CNT_W-1:0] CYC_HIGH  = `ASFP_CNT_W'(`ASFP_CYC_HIGH);
    localparam logic [`ASFP_CNT_W-1:0] CYC_SETUP = `ASFP_CNT_W'(`ASFP_CYC_SETUP);
    localparam logic [`ASFP_CNT_W-1:0] CYC_ACC   = `ASFP_CNT_W'(`ASFP_CYC_ACC);

    asfp_pkg::asfp_state_e     state;
    asfp_pkg::asfp_state_e     next_state;
    asfp_pkg::asfp_op_e        op;
    logic [`ASFP_CNT_W-1:0]    cnt;
    logic [`ASFP_CNT_W-1:0]    next_cnt;
    logic [`ASFP_DATA_W-1:0]   din_meta;
    logic [`ASFP_DATA_W-1:0]   din_sync;
    logic [`ASFP_DATA_W-1:0]   cap_data;
    logic                      cap_valid;
    logic [`ASFP_CNT_W-1:0]    acc_cnt;

    asfp_stream_if fill_s ();
    asfp_stream_if drain_s ();

    asfp_fifo #(
        .WIDTH (`ASFP_DATA_W),
        .DEPTH (`ASFP_FIFO_DEPTH)
    ) u_rd_fifo (
        .clk   (clk),
        .rst_b (rst_b),
        .in_s  (fill_s),
        .out_s (drain_s)
    );

    assign fill_s.data   = cap_data;
    assign fill_s.valid  = cap_valid;
    // The output word register keeps rd_data and rd_valid straight off flops.
    // It refills in the cycle it empties, so a steady sink still gets one word per clock.
    assign drain_s.ready = !rd_valid || rd_ready;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else if (drain_s.ready) begin
            rd_valid <= drain_s.valid;
            rd_data  <= drain_s.data;
        end
    end

    // Decode of the current operation and its phase
    wire cnt_done  = (cnt == '0);
    wire is_read   = (op == asfp_pkg::ASFP_OP_READ);
    wire in_idle   = (state == asfp_pkg::ASFP_ST_IDLE);
    wire in_low    = (state == asfp_pkg::ASFP_ST_LOW);
    // A read is only started when the FIFO can take its word, so reads stall on back-pressure
    wire rd_room   = fill_s.ready;
    wire cmd_is_rd = (cmd_op == 2'(asfp_pkg::ASFP_OP_READ));
    wire take_cmd  = in_idle && cmd_valid && (!cmd_is_rd || rd_room);
    wire sample_rd = in_low && is_read && (acc_cnt == CYC_ACC);
    // Operation in force on the next cycle; pins are registered from it
    wire [1:0] next_op        = take_cmd ? cmd_op : 2'(op);
    wire       next_is_read   = (next_op == 2'(asfp_pkg::ASFP_OP_READ));
    wire       next_is_write  = (next_op == 2'(asfp_pkg::ASFP_OP_WRITE));
    wire       next_is_commit = (next_op == 2'(asfp_pkg::ASFP_OP_COMMIT));

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            asfp_pkg::ASFP_ST_IDLE: begin
                if (take_cmd) begin
                    // R08 select and chip select settle before any strobe
                    next_state = asfp_pkg::ASFP_ST_SETUP;
                    next_cnt   = CYC_SETUP - 1'b1;
                end
            end
            asfp_pkg::ASFP_ST_SETUP: begin
                if (cnt_done) begin
                    next_state = asfp_pkg::ASFP_ST_LOW;
                    next_cnt   = CYC_LOW - 1'b1;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            asfp_pkg::ASFP_ST_LOW: begin
                if (cnt_done && (!is_read || cap_valid || acc_cnt > CYC_ACC)) begin
                    // R18 low width held before the rising edge
                    next_state = asfp_pkg::ASFP_ST_HIGH;
                    next_cnt   = CYC_HIGH - 1'b1;
                end else if (!cnt_done) begin
                    next_cnt = cnt - 1'b1;
                end
            end
            asfp_pkg::ASFP_ST_HIGH: begin
                // R16 high width before any following strobe, packet-end included
                if (cnt_done) begin
                    next_state = asfp_pkg::ASFP_ST_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = asfp_pkg::ASFP_ST_IDLE;
                next_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= asfp_pkg::ASFP_ST_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            op <= asfp_pkg::ASFP_OP_READ;
        end else if (take_cmd) begin
            op <= asfp_pkg::asfp_op_e'(cmd_op);
        end
    end

    // Read data comes from pins, so it passes two flops
    always_ff @(posedge clk) begin
        din_meta <= fifo_data_in;
        din_sync <= din_meta;
    end

    // Access counter covers the slave delay alone; the two sync stages are not added
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acc_cnt <= '0;
        end else if (in_low && is_read) begin
            acc_cnt <= (acc_cnt == '1) ? acc_cnt : acc_cnt + 1'b1;
        end else begin
            acc_cnt <= '0;
        end
    end

    // R04 capture takes the pin value from 3 cycles (24 ns) after the strobe fall, short of the 30 ns access delay
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cap_valid <= 1'b0;
            cap_data  <= '0;
        end else begin
            cap_valid <= sample_rd;
            if (sample_rd) begin
                cap_data <= din_sync;
            end
        end
    end

    // Pin drive: registered, one flop per pin
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fifo_chip_select_n     <= 1'b1;
            fifo_output_enable_n   <= 1'b1;
            fifo_read_strobe_n     <= 1'b1;
            fifo_write_strobe_n    <= 1'b1;
            packet_commit_strobe_n <= 1'b1;
            fifo_select_bus        <= '0;
            fifo_data_out          <= '0;
            fifo_data_oe           <= 1'b0;
            cmd_ready              <= 1'b0;
        end else begin
            cmd_ready <= (next_state == asfp_pkg::ASFP_ST_IDLE) && !take_cmd;
            if (take_cmd) begin
                // R17 select held from here until the cycle ends
                fifo_select_bus <= cmd_sel;
                fifo_data_out   <= cmd_wdata;
            end
            // R02 R09 chip select leads every strobe and trails it
            fifo_chip_select_n <= (next_state == asfp_pkg::ASFP_ST_IDLE);
            // R01 R05 R06 output enable and read strobe move together
            fifo_output_enable_n <= !((next_state == asfp_pkg::ASFP_ST_LOW) && next_is_read);
            fifo_read_strobe_n   <= !((next_state == asfp_pkg::ASFP_ST_LOW) && next_is_read);
            // R10 R11 data driven from setup through the rising write edge
            fifo_data_oe <= (next_state != asfp_pkg::ASFP_ST_IDLE) && next_is_write;
            // R15 write and packet-end come from exclusive operations
            fifo_write_strobe_n <= !((next_state == asfp_pkg::ASFP_ST_LOW) && next_is_write);
            // R14 packet-end pulse commits the selected FIFO
            packet_commit_strobe_n <= !((next_state == asfp_pkg::ASFP_ST_LOW) && next_is_commit);
        end
    end

endmodule : asfp_master

/* asfp_master_sva.sv */
// Pin-level checker for the slave FIFO port master
`timescale 1ns/1ps
`include "asfp_params.svh"
module asfp_master_sva (
    input wire logic                    clk,
    input wire logic                    rst_b,
    input wire logic                    fifo_chip_select_n,
    input wire logic                    fifo_output_enable_n,
    input wire logic                    fifo_read_strobe_n,
    input wire logic                    fifo_write_strobe_n,
    input wire logic                    packet_commit_strobe_n,
    input wire logic [`ASFP_SEL_W-1:0]  fifo_select_bus,
    input wire logic [`ASFP_DATA_W-1:0] fifo_data_out,
    input wire logic                    fifo_data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [3:0] hi_cnt;
    // Starts saturated so a commit with no write before it is legal
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hi_cnt <= 4'hF;
        end else if (!fifo_write_strobe_n) begin
            hi_cnt <= 4'h0;
        end else if (hi_cnt != 4'hF) begin
            hi_cnt <= hi_cnt + 4'h1;
        end
    end
    strobe_excl_a: assert property (fifo_write_strobe_n || packet_commit_strobe_n)
        else $error("write and commit strobes low together");
    rd_cs_first_a: assert property ($fell(fifo_read_strobe_n) |-> !$past(fifo_chip_select_n))
        else $error("read strobe fell without chip select before it");
    wr_cs_a: assert property (!fifo_write_strobe_n |-> !fifo_chip_select_n)
        else $error("write strobe low without chip select");
    rd_oe_a: assert property (!fifo_read_strobe_n |-> !fifo_output_enable_n && !fifo_data_oe)
        else $error("read without output enable or with bus driven");
    wr_hold_a: assert property (!fifo_write_strobe_n |-> fifo_data_oe && $stable(fifo_select_bus)
        && $stable(fifo_data_out))
        else $error("select or data moved during write strobe");
    pe_sel_hold_a: assert property (!packet_commit_strobe_n |-> $stable(fifo_select_bus))
        else $error("select moved during commit strobe");
    wr_width_a: assert property ($fell(fifo_write_strobe_n) |-> (!fifo_write_strobe_n) [*7])
        else $error("write strobe low too briefly");
    rd_width_a: assert property ($fell(fifo_read_strobe_n) |-> (!fifo_read_strobe_n) [*7])
        else $error("read strobe low too briefly");
    pe_gap_a: assert property ($fell(packet_commit_strobe_n) |-> hi_cnt >= 4'h7)
        else $error("commit too soon after write strobe");
endmodule : asfp_master_sva

bind asfp_master asfp_master_sva u_sva (.clk(clk), .rst_b(rst_b),
    .fifo_chip_select_n(fifo_chip_select_n), .fifo_output_enable_n(fifo_output_enable_n),
    .fifo_read_strobe_n(fifo_read_strobe_n), .fifo_write_strobe_n(fifo_write_strobe_n),
    .packet_commit_strobe_n(packet_commit_strobe_n), .fifo_select_bus(fifo_select_bus),
    .fifo_data_out(fifo_data_out), .fifo_data_oe(fifo_data_oe));

/* asfp_master_test.sv */
// Self-checking bench for the slave FIFO port master
`timescale 1ns/1ps
`include "asfp_params.svh"
module asfp_master_test;
    logic        clk, rst_b, cmd_valid, cmd_ready, rd_valid, rd_ready, oe;
    logic        cs_n, oe_n, rd_n, wr_n, pe_n;
    logic [1:0]  cmd_op, cmd_sel, sel;
    logic [7:0]  cmd_wdata, rd_data, din, dout, last_len, want;
    logic [7:0]  w [4];
    logic [7:0]  exp_q [$];
    logic [31:0] seed = 32'hA748;
    int          num_errors = 0;
    int          check_count = 0;

    asfp_master dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .fifo_chip_select_n(cs_n),
        .fifo_output_enable_n(oe_n), .fifo_read_strobe_n(rd_n), .fifo_write_strobe_n(wr_n),
        .packet_commit_strobe_n(pe_n), .fifo_select_bus(sel), .fifo_data_in(dout),
        .fifo_data_out(din), .fifo_data_oe(oe));
    asfp_slave_model slave (.sel(sel), .cs_n(cs_n), .oe_n(oe_n), .rd_n(rd_n), .wr_n(wr_n),
        .pe_n(pe_n), .din(din), .dout(dout), .last_len(last_len));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic wait_rdy(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cmd_ready !== lvl && n < 300);
        if (n >= 300) begin
            num_errors++;
            results();
        end
    endtask : wait_rdy
    // Holds the request until a negedge shows ready, so the next edge takes it
    task automatic op(input logic [1:0] o, input logic [1:0] s, input logic [7:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_sel <= s;
        cmd_wdata <= d;
        wait_rdy(1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
        wait_rdy(1'b0);
    endtask : op

    // Read words leave in request order
    always @(posedge clk) begin
        if (rd_valid === 1'b1 && rd_ready) begin
            want = (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data;
            check(rd_data, want);
        end
    end

    initial begin
        rst_b = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_sel = 2'h0;
        cmd_wdata = 8'h00;
        rd_ready = 1'b1;
        repeat (12) @(posedge clk);
        check({3'h0, cs_n, rd_n, wr_n, pe_n, oe}, 8'h1E);
        rst_b <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i <= s; i++) begin
                seed = xs(seed);
                w[i] = seed[7:0];
                op(asfp_pkg::ASFP_OP_WRITE, s[1:0], w[i]);
            end
            op(asfp_pkg::ASFP_OP_COMMIT, s[1:0], 8'h00);
            wait_rdy(1'b1);
            check(last_len, 8'(s + 1));
            @(posedge clk);
            rd_ready <= (s != 3);
            for (int i = 0; i <= s; i++) begin
                exp_q.push_back(w[i]);
                op(asfp_pkg::ASFP_OP_READ, s[1:0], 8'h00);
            end
        end
        // Four words held and stalled: the head word must stay offered
        wait_rdy(1'b1);
        repeat (10) @(posedge clk);
        check({7'h0, rd_valid}, 8'h01);
        check(8'(exp_q.size()), 8'h04);
        rd_ready <= 1'b1;
        for (int n = 0; n < 50 && exp_q.size() > 0; n++) @(posedge clk);
        check(8'(exp_q.size()), 8'h00);
        results();
    end
endmodule : asfp_master_test

/* asfp_params.svh */
// Constants for the asynchronous slave FIFO port master
`ifndef ASFP_PARAMS_SVH
`define ASFP_PARAMS_SVH

`define ASFP_DATA_W        8
`define ASFP_SEL_W         2
`define ASFP_FIFO_DEPTH    4
`define ASFP_CLK_PERIOD_PS 8000
// Strobe low and high widths, select setup and read access, in ps
`define ASFP_T_STROBE_LOW_PS  50000
`define ASFP_T_STROBE_HIGH_PS 50000
`define ASFP_T_SEL_SETUP_PS   10000
`define ASFP_T_READ_ACC_PS    30000
// Least times round up to whole cycles
`define ASFP_CYC_LOW  ((`ASFP_T_STROBE_LOW_PS + `ASFP_CLK_PERIOD_PS - 1) / `ASFP_CLK_PERIOD_PS)
`define ASFP_CYC_HIGH ((`ASFP_T_STROBE_HIGH_PS + `ASFP_CLK_PERIOD_PS - 1) / `ASFP_CLK_PERIOD_PS)
`define ASFP_CYC_SETUP ((`ASFP_T_SEL_SETUP_PS + `ASFP_CLK_PERIOD_PS - 1) / `ASFP_CLK_PERIOD_PS)
`define ASFP_CYC_ACC  ((`ASFP_T_READ_ACC_PS + `ASFP_CLK_PERIOD_PS - 1) / `ASFP_CLK_PERIOD_PS)
`define ASFP_CNT_W    4

`endif

/* asfp_pkg.sv */
// Types for the asynchronous slave FIFO port master
package asfp_pkg;
    typedef enum logic [1:0] {
        ASFP_OP_READ,
        ASFP_OP_WRITE,
        ASFP_OP_COMMIT
    } asfp_op_e;

    typedef enum logic [2:0] {
        ASFP_ST_IDLE,
        ASFP_ST_SETUP,
        ASFP_ST_LOW,
        ASFP_ST_HIGH
    } asfp_state_e;
endpackage : asfp_pkg

/* asfp_slave_model.sv */
// Behavioural slave device with four endpoint buffers
`timescale 1ns/1ps
`include "asfp_params.svh"
module asfp_slave_model #(
    parameter int T_XFD_NS = 12
) (
    input  wire logic [1:0] sel,
    input  wire logic       cs_n,
    input  wire logic       oe_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       pe_n,
    input  wire logic [7:0] din,
    output logic [7:0]      dout,
    output logic [7:0]      last_len
);
    logic [7:0] mem [4][16];
    logic [3:0] wp [4];
    logic [3:0] rp [4];
    logic [3:0] cp [4];
    logic [7:0] shown = 8'h00;
    initial begin
        wp = '{default: 4'h0};
        rp = '{default: 4'h0};
        cp = '{default: 4'h0};
        last_len = 8'h00;
    end
    // bus only with enable; released bus shows inverse
    assign dout = (!cs_n && !oe_n) ? shown : ~shown;
    always @(negedge rd_n) begin
        if (!cs_n) begin
            #(T_XFD_NS) shown = mem[sel][rp[sel]];
            rp[sel] = rp[sel] + 4'h1;
        end
    end
    // store on rising edge, post increment
    always @(posedge wr_n) begin
        if (!cs_n) begin
            mem[sel][wp[sel]] = din;
            wp[sel] = wp[sel] + 4'h1;
        end
    end
    always @(negedge pe_n) begin
        if (!cs_n) begin
            last_len = {4'h0, wp[sel] - cp[sel]};
            cp[sel] = wp[sel];
        end
    end
endmodule : asfp_slave_model

/* asfp_stream_if.sv */
// Valid/ready stream between the port master and its FIFO
`timescale 1ns/1ps
`include "asfp_params.svh"
interface asfp_stream_if;
    logic [`ASFP_DATA_W-1:0] data;
    logic                    valid;
    logic                    ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : asfp_stream_if
